// ### logic/sdmp_pkg.sv
// Purpose: shared constants for the move prediction block
// Assumes: one decoder clock, axi4-lite register access
// Notes: offsets are byte addresses of aligned words
package sdmp_pkg;
	localparam int unsigned SDMP_CLK_MHZ = 250;
	localparam logic [7:0] SDMP_OFF_CTRL = 8'h00;
	localparam logic [7:0] SDMP_OFF_STAT = 8'h04;
	localparam logic [7:0] SDMP_OFF_METRIC = 8'h08;
	localparam logic [3:0] SDMP_DELTA_FIVE = 4'h5;
	localparam logic [3:0] SDMP_DELTA_SIX = 4'h6;
	localparam logic [3:0] SDMP_DELTA_RST = 4'h5;
	localparam logic [1:0] SDMP_RESP_OKAY = 2'h0;
	localparam logic [1:0] SDMP_RESP_SLVERR = 2'h2;
	localparam int SDMP_CTRL_DELTA_LSB = 0;
	localparam int SDMP_CTRL_DELTA_W = 4;
	localparam int SDMP_CTRL_RUN_BIT = 4;
	localparam logic [3:0] SDMP_METRIC_ONE = 4'h1;
endpackage : sdmp_pkg

// ### logic/sdmp_axil_slave.sv
// Purpose: axi4-lite slave for the prediction block registers
// Assumes: one write and one read in flight at most
// Notes: unmapped addresses answer slverr, read as zero
`timescale 1ns/1ps
`default_nettype none
module sdmp_axil_slave
	import sdmp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] ctrl_q,
	input wire logic [31:0] stat_in,
	input wire logic [31:0] metric_in
);
	logic aw_held_q;
	logic w_held_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	wire aw_take = s_axi_awvalid && awready_q;
	wire w_take = s_axi_wvalid && wready_q;
	wire aw_have = aw_held_q || aw_take;
	wire w_have = w_held_q || w_take;
	wire [7:0] aw_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] w_data = w_held_q ? wdata_q : s_axi_wdata;
	wire [3:0] w_strb = w_held_q ? wstrb_q : s_axi_wstrb;
	wire wr_go = aw_have && w_have && !bvalid_q;
	wire wr_ctrl = wr_go && (aw_addr == SDMP_OFF_CTRL);
	wire wr_map = (aw_addr == SDMP_OFF_CTRL);
	wire ar_take = s_axi_arvalid && arready_q;
	wire rd_stat = s_axi_araddr == SDMP_OFF_STAT;
	wire rd_ctl = s_axi_araddr == SDMP_OFF_CTRL;
	wire rd_met = s_axi_araddr == SDMP_OFF_METRIC;
	wire rd_map = rd_stat || rd_ctl || rd_met;
	wire [31:0] rd_word = rd_ctl ? ctrl_q : (rd_stat ? stat_in : (rd_met ? metric_in : 32'h0));
	logic [31:0] ctrl_d;
	always_comb
	begin
		ctrl_d = ctrl_q;
		for (int i = 0; i < 4; i++)
		begin
			if (w_strb[i])
			begin
				ctrl_d[i*8 +: 8] = w_data[i*8 +: 8];
			end
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= SDMP_RESP_OKAY;
			ctrl_q <= {27'h0, 1'b0, SDMP_DELTA_RST};
		end
		else
		begin
			if (wr_go)
			begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_map ? SDMP_RESP_OKAY : SDMP_RESP_SLVERR;
			end
			else
			begin
				aw_held_q <= aw_have;
				w_held_q <= w_have;
				if (bvalid_q && s_axi_bready)
				begin
					bvalid_q <= 1'b0;
				end
			end
			if (aw_take)
			begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			awready_q <= !aw_have && !awready_q && !bvalid_q;
			wready_q <= !w_have && !wready_q && !bvalid_q;
			if (wr_ctrl)
			begin
				ctrl_q <= ctrl_d;
			end
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= SDMP_RESP_OKAY;
		end
		else
		begin
			arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
			if (ar_take)
			begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= rd_map ? SDMP_RESP_OKAY : SDMP_RESP_SLVERR;
			end
			else if (rvalid_q && s_axi_rready)
			begin
				rvalid_q <= 1'b0;
			end
		end
	end
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
endmodule : sdmp_axil_slave
`default_nettype wire

// ### logic/sdmp_move_predict.sv
// Purpose: one-clock-ahead prediction of threshold lowering, poly enable and move
// Assumes: syndrome and metric logic on the same clock as aclk
// Notes: max_rev_in is valid before the loading edge
`timescale 1ns/1ps
`default_nettype none
module sdmp_move_predict
	import sdmp_pkg::*;
#(
	parameter int DELTA_W = 4,
	parameter int MOD_W = 3
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic [7:0] s_axi_awaddr,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic synd_in,
	input wire logic info_in,
	input wire logic synd_young_in,
	input wire logic poly_young_in,
	input wire logic err_old_in,
	input wire logic par_old_in,
	input wire logic err_older_in,
	input wire logic par_older_in,
	input wire logic exhausted_in,
	input wire logic max_rev_in,
	input wire logic [DELTA_W-1:0] delta_cnt_in,
	input wire logic [MOD_W-1:0] mod_cnt_in,
	output logic lower_q,
	output logic poly_en_q,
	output logic fwd_q,
	output logic rev_q,
	output logic poly_add_q,
	output logic hyp_err_q,
	output logic hyp_par_q
);
	logic [31:0] ctrl_q;
	logic dsel_q;
	logic [31:0] stat_w;
	logic [31:0] metric_w;
	wire [3:0] delta_sel = ctrl_q[SDMP_CTRL_DELTA_LSB +: SDMP_CTRL_DELTA_W];
	wire run = ctrl_q[SDMP_CTRL_RUN_BIT];
	// metric held split as delta stages above modulo stages
	wire [DELTA_W+MOD_W-1:0] metric = {delta_cnt_in, mod_cnt_in};
	wire m_is_one = (delta_cnt_in == '0) && (mod_cnt_in == MOD_W'(SDMP_METRIC_ONE));
	// delta minus one: zero delta stages, modulo counter top bit set and low bit equal to dsel_q
	wire m_is_dm1 = (delta_cnt_in == '0) && (mod_cnt_in[MOD_W-1] == 1'b1) && (mod_cnt_in[0] == dsel_q);
	// predicted syndrome bit
	wire synd_pred = synd_young_in ^ (poly_young_in & poly_en_q);
	wire lower_fwd = m_is_dm1 && !synd_in && !info_in && synd_pred && fwd_q;
	wire old_clr = !err_old_in && !par_old_in;
	wire older_clr = !err_older_in && !par_older_in;
	wire lower_rev = m_is_one && old_clr && older_clr && rev_q;
	wire lower_d = lower_fwd || lower_rev || max_rev_in;
	wire rev_s = err_old_in ^ par_old_in;
	wire rev_lt = (m_is_one && old_clr && older_clr) || max_rev_in;
	wire rev_qual = (rev_s && rev_lt) || (!rev_s && !rev_lt);
	wire poly_en_d = fwd_q ? synd_pred : rev_qual;
	wire poly_add_d = (poly_en_q && fwd_q) || (err_old_in && rev_q);
	// threshold test on previous metric
	wire meets = delta_cnt_in[DELTA_W-1] || delta_cnt_in[DELTA_W-2] || delta_cnt_in[1]
		|| (delta_cnt_in[0] && mod_cnt_in[MOD_W-1] && !dsel_q)
		|| ((delta_cnt_in[0] || (mod_cnt_in[MOD_W-1] && !dsel_q)) && synd_in)
		|| (!synd_in && !info_in);
	wire fwd_now = meets && !exhausted_in;
	wire exh_pred = par_old_in && rev_q;
	wire big = (delta_cnt_in[DELTA_W-1] || delta_cnt_in[DELTA_W-2]) && !exh_pred;
	wire cont_fwd = !synd_pred && fwd_q;
	wire exh_fwd = err_old_in && !par_old_in && rev_q;
	wire exh_rev = !err_old_in && par_old_in && rev_q && !max_rev_in;
	wire min_ok = (delta_cnt_in[1] || delta_cnt_in[0]) && synd_pred && fwd_q
		|| (old_clr && delta_cnt_in[1] && rev_q);
	wire fwd_d = !exh_rev && (cont_fwd || exh_fwd || min_ok || big || fwd_now && lower_d);
	wire dsel_d = (delta_sel == SDMP_DELTA_SIX) ? mod_cnt_in[0] : !mod_cnt_in[0];
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run)
		begin
			lower_q <= 1'b0;
			poly_en_q <= 1'b0;
			fwd_q <= 1'b1;
			rev_q <= 1'b0;
			poly_add_q <= 1'b0;
			hyp_err_q <= 1'b0;
			hyp_par_q <= 1'b0;
			dsel_q <= 1'b0;
		end
		else
		begin
			lower_q <= lower_d && !exh_rev;
			poly_en_q <= poly_en_d;
			fwd_q <= fwd_d;
			rev_q <= !fwd_d;
			poly_add_q <= poly_add_d;
			hyp_err_q <= synd_in && fwd_q;
			hyp_par_q <= exh_fwd;
			dsel_q <= dsel_d;
		end
	end
	assign stat_w = {25'h0, hyp_par_q, hyp_err_q, poly_add_q, rev_q, fwd_q, poly_en_q, lower_q};
	assign metric_w = {{(32-DELTA_W-MOD_W){1'b0}}, metric};
	sdmp_axil_slave u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.ctrl_q(ctrl_q),
		.stat_in(stat_w),
		.metric_in(metric_w)
	);
	a_fwd_rev_compl: assert property (@(posedge aclk) disable iff (!aresetn) fwd_q != rev_q) else $error("fwd and rev equal");
	a_lower_cause: assert property (@(posedge aclk) disable iff (!aresetn) run && $past(run) && lower_q |-> $past(max_rev_in) || $past(lower_fwd) || $past(lower_rev)) else $error("lower without cause");
	a_poly_fwd_gate: assert property (@(posedge aclk) disable iff (!aresetn) run && fwd_q && poly_en_q |=> poly_add_q || !run) else $error("forward add missed");
	a_poly_rev_add: assert property (@(posedge aclk) disable iff (!aresetn) run && rev_q && err_old_in |=> poly_add_q || !run) else $error("reverse add missed");
	a_exh_second_rev: assert property (@(posedge aclk) disable iff (!aresetn) run && exh_rev |=> rev_q || !run) else $error("second reverse missed");
	a_cont_forward: assert property (@(posedge aclk) disable iff (!aresetn) run && cont_fwd && !exh_rev |=> fwd_q || !run) else $error("forward not continued");
	a_exh_forward: assert property (@(posedge aclk) disable iff (!aresetn) run && exh_fwd |=> fwd_q && hyp_par_q || !run) else $error("exhausted forward missed");
	a_poly_en_load: assert property (@(posedge aclk) disable iff (!aresetn) run && fwd_q |=> poly_en_q == $past(synd_pred) || !run) else $error("poly enable wrong");
	a_dsel_six: assert property (@(posedge aclk) disable iff (!aresetn) run && delta_sel == SDMP_DELTA_SIX |=> dsel_q == $past(mod_cnt_in[0]) || !run) else $error("delta select wrong");
endmodule : sdmp_move_predict
`default_nettype wire

// ### verification/sdmp_far_model.sv
// Purpose: far-side model of the syndrome shift register and the metric counter
// Assumes: same clock as the prediction block
// Notes: error and syndrome bits are random, the metric counter follows the moves
`timescale 1ns/1ps
`default_nettype none
module sdmp_far_model
	import sdmp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic fwd_in,
	input wire logic quiet,
	input wire logic force_max,
	output logic [7:0] bits_q,
	output logic exh_q,
	output logic max_q,
	output logic [3:0] delta_q,
	output logic [2:0] mod_q
);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bits_q <= 8'h00;
			exh_q <= 1'b0;
			max_q <= 1'b0;
			delta_q <= 4'h0;
			mod_q <= 3'h0;
		end
		else
		begin
			bits_q <= 8'($urandom);
			exh_q <= !quiet && ($urandom % 4 == 0);
			// settled a whole period before the loading edge
			max_q <= force_max || (!quiet && ($urandom % 8 == 0));
			mod_q <= fwd_in ? mod_q + 3'h1 : mod_q - 3'h1;
			delta_q <= (fwd_in && mod_q == 3'h7) ? delta_q + 4'h1 : delta_q;
		end
	end
endmodule : sdmp_far_model
`default_nettype wire

// ### verification/sdmp_move_predict_tb_top.sv
// Purpose: self-checking bench of the move prediction block
// Assumes: far-side model feeds the prediction inputs every clock
// Notes: random inputs from a fixed seed, register access over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module sdmp_move_predict_tb_top;
	import sdmp_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, dcnt;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic lower_q, poly_en_q, fwd_q, rev_q, poly_add_q, hyp_err_q, hyp_par_q;
	logic exh, mx, quiet, force_max, live, f, pe, e, m;
	logic [7:0] bits, b;
	logic [2:0] mcnt;
	int mismatches, cmp_count;
	logic [3:0] m_dl [2] = '{SDMP_DELTA_FIVE, SDMP_DELTA_SIX};
	wire [6:0] outs = {hyp_par_q, hyp_err_q, poly_add_q, rev_q, fwd_q, poly_en_q, lower_q};
	sdmp_move_predict DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .synd_in(bits[0]), .info_in(bits[1]),
		.synd_young_in(bits[2]), .poly_young_in(bits[3]), .err_old_in(bits[4]),
		.par_old_in(bits[5]), .err_older_in(bits[6]), .par_older_in(bits[7]),
		.exhausted_in(exh), .max_rev_in(mx), .delta_cnt_in(dcnt), .mod_cnt_in(mcnt),
		.lower_q(lower_q), .poly_en_q(poly_en_q), .fwd_q(fwd_q), .rev_q(rev_q),
		.poly_add_q(poly_add_q), .hyp_err_q(hyp_err_q), .hyp_par_q(hyp_par_q));
	sdmp_far_model far (.aclk(aclk), .aresetn(aresetn), .fwd_in(fwd_q), .quiet(quiet),
		.force_max(force_max), .bits_q(bits), .exh_q(exh), .max_q(mx), .delta_q(dcnt),
		.mod_q(mcnt));
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	function automatic logic sp_f(input logic [7:0] bv, input logic pen);
		return bv[2] ^ (bv[3] & pen);
	endfunction : sp_f
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rv);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= dv;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			aw = aw | (s_axi_awvalid & s_axi_awready);
			w = w | (s_axi_wvalid & s_axi_wready);
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end while (!(aw && w));
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		rv = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		dv = s_axi_rdata;
		rv = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	// outputs stay at reset values while run is clear
	task automatic idle_chk();
		repeat (4)
		begin
			@(posedge aclk);
			#1 chk(32'(outs), 32'h4);
		end
		@(posedge aclk);
	endtask : idle_chk
	always @(posedge aclk)
	begin
		if (live)
		begin
			f = fwd_q;
			pe = poly_en_q;
			b = bits;
			e = exh;
			m = mx;
			#1;
			chk(32'(rev_q), 32'(!fwd_q));
			if (f) chk(32'(poly_en_q), 32'(sp_f(b, pe)));
			if (f && !sp_f(b, pe) && !e && !m) chk(32'(fwd_q), 32'h1);
			if (m) chk(32'(lower_q), 32'h1);
			chk(32'(poly_add_q), 32'(f ? pe : b[4]));
			if (f && b[0]) chk(32'({hyp_err_q, hyp_par_q}), 32'h2);
			if (!f && b[4] && !b[5]) chk(32'({fwd_q, hyp_par_q}), 32'h3);
			if (!f && !b[4] && b[5] && !m) chk(32'({fwd_q, lower_q}), 32'h0);
		end
	end
	initial
	begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		test_done();
	end
	initial
	begin
		void'($urandom(88615));
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		{aresetn, quiet, force_max, live} = 4'h4;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			idle_chk();
			axi_rd(SDMP_OFF_CTRL, d, r);
			chk(d, 32'h5);
			axi_rd(8'h0c, d, r);
			chk(d, 32'h0);
			chk(32'(r), 32'(SDMP_RESP_SLVERR));
			axi_wr(8'h10, 32'h15, r);
			chk(32'(r), 32'(SDMP_RESP_SLVERR));
			foreach (m_dl[i])
			begin
				axi_wr(SDMP_OFF_CTRL, 32'h10 | 32'(m_dl[i]), r);
				axi_rd(SDMP_OFF_CTRL, d, r);
				chk(d, 32'h10 | 32'(m_dl[i]));
				repeat (2) @(posedge aclk);
				live <= 1'b1;
				repeat (300) @(posedge aclk);
				quiet <= 1'b0;
				repeat (300) @(posedge aclk);
				force_max <= 1'b1;
				@(posedge aclk);
				{force_max, quiet} <= 2'h1;
			end
			live <= 1'b0;
			aresetn <= 1'b0;
			repeat (2) @(posedge aclk);
			aresetn <= 1'b1;
		end
		test_done();
	end
endmodule : sdmp_move_predict_tb_top
`default_nettype wire
